/* rtl/rsa_defines.vh */
// Purpose: constants of the rectifier status and alarm read-back bank
// Assumes: byte-level serial front end outside this block
// Notes: definitions only
`ifndef RSA_DEFINES_VH
`define RSA_DEFINES_VH

// ==========================================
// command codes
`define RSA_CMD_SUMMARY 8'hd0
`define RSA_CMD_UNIT 8'hd1
`define RSA_CMD_ALARM 8'hd2

// ==========================================
// frame sizes
`define RSA_SUMMARY_COUNT 8'h0b
`define RSA_ALARM_COUNT 8'h03
`define RSA_SUMMARY_LEN 4'hc
`define RSA_UNIT_LEN 4'h2
`define RSA_ALARM_LEN 4'h4
`define RSA_FILL_BYTE 8'hff

// ==========================================
// reset values
`define RSA_UNIT_HIGH_RST 8'h40
`define RSA_UNIT_LOW_RST 8'h80
`define RSA_ALARM_RST 8'h00

// ==========================================
// unit_flags_high fields
`define RSA_UH_PEC_ERR 7
`define RSA_UH_OC_HICCUP 6
`define RSA_UH_BAD_INSTR 5
`define RSA_UH_ORNG_FAIL 3
`define RSA_UH_RANGE 1
`define RSA_UH_REMOTE_ON 0

// ==========================================
// alarm fields
`define RSA_A3_ORNG 0
`define RSA_A2_POWER_DELIVERY 0

// ==========================================
// power delivery threshold, share current in milliamps
`define RSA_SHARE_LIMIT_MA 16'd10000

// ==========================================
// packet error check
`define RSA_PEC_POLY 8'h07
`define RSA_PEC_INIT 8'h00

`endif

/* rtl/rsa_pec8.v */
// Purpose: one-byte update of the packet error check code
// Assumes: polynomial x8+x2+x+1, msb first
// Notes: purely combinational
`timescale 1ns/1ps
`include "rsa_defines.vh"

module rsa_pec8 (
	input wire [7:0] crc_i,
	input wire [7:0] data_i,
	output reg [7:0] crc_o
);

	integer k;
	reg [7:0] c;

	always @* begin
		c = crc_i ^ data_i;
		for (k = 0; k < 8; k = k + 1) begin
			if (c[7])
				c = {c[6:0], 1'b0} ^ `RSA_PEC_POLY;
			else
				c = {c[6:0], 1'b0};
		end
		crc_o = c;
	end

endmodule // rsa_pec8

/* rtl/rsa_bank.v */
// Purpose: status and alarm register bank with serial read-back frames
// Assumes: front end hands over command, repeated start and byte requests
// Notes: frame is snapshotted at the repeated start for coherence
//
// Summary of operation
// - command 0xd0 answers a block read whose byte count is 11.
// - summary order: unit pair, alarms 3 2 1, volts, amps, temp, then pec.
// - summary temperature is the sensor nearest its shutdown limit.
// - command 0xd1 returns unit high byte then unit low byte as a word read.
// - command 0xd2 returns alarm three, two, one in that order.
// - the five bytes read together or as unit pair and alarm batch.
// - unit high bit 0 follows the remote on/off input level.
// - alarm three holds interlock, fuse, three link faults, or'ing fault.
// - or'ing fault is set by a failing host test or a failing internal test.
// - a destructive or'ing fault shuts the output down.
// - a non-destructive or'ing fault is only flagged.
// - power delivery alarm rises when share current exceeds 10 A.
// - block reads lead with a byte count without pec, analog lsb first.
`timescale 1ns/1ps
`include "rsa_defines.vh"

module rsa_bank #(
	parameter NSENS = 3,
	parameter [6:0] SLAVE_ADDR = 7'h58
) (
	input wire clk_i,
	input wire rstn_i,
	input wire cmd_valid_i,
	input wire [7:0] cmd_code_i,
	input wire rd_start_i,
	input wire rd_req_i,
	input wire pec_err_i,
	input wire oc_hiccup_i,
	input wire bad_instr_i,
	input wire value_range_flag_i,
	input wire remote_on_i,
	input wire ot_hiccup_i,
	input wire orng_ok_i,
	input wire internal_fault_i,
	input wire shutdown_i,
	input wire service_led_i,
	input wire external_fault_i,
	input wire led_test_i,
	input wire output_on_i,
	input wire [4:0] alarm_three_src_i,
	input wire [6:0] alarm_two_src_i,
	input wire [7:0] alarm_one_src_i,
	input wire host_test_fail_i,
	input wire self_test_fail_i,
	input wire orng_destructive_i,
	input wire orng_clear_i,
	input wire [15:0] share_ma_i,
	input wire [15:0] vout_i,
	input wire [15:0] iout_i,
	input wire [NSENS*16-1:0] temp_i,
	input wire [NSENS*16-1:0] temp_limit_i,
	output reg [7:0] rd_data_o,
	output reg rd_valid_o,
	output reg out_shutdown_o,
	output reg orng_fault_o
);

	// ==========================================
	// flag registers
	reg [7:0] unit_flags_high_reg;
	reg [7:0] unit_flags_low_reg;
	reg [7:0] alarm_byte_three_reg;
	reg [7:0] alarm_byte_two_reg;
	reg [7:0] alarm_byte_one_reg;
	reg host_fail_reg;
	reg orng_next;
	reg shut_next;
	reg host_fail_next;

	always @* begin
		orng_next = orng_fault_o;
		shut_next = out_shutdown_o;
		host_fail_next = host_fail_reg;
		if (orng_clear_i) begin
			orng_next = 1'b0;
			shut_next = 1'b0;
			host_fail_next = 1'b0;
		end
		// set wins over clear
		if (host_test_fail_i || self_test_fail_i)
			orng_next = 1'b1;
		if (host_test_fail_i)
			host_fail_next = 1'b1;
		// destructive fault shuts down, otherwise flag only
		if ((host_test_fail_i || self_test_fail_i) && orng_destructive_i)
			shut_next = 1'b1;
	end

	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			orng_fault_o <= 1'b0;
			out_shutdown_o <= 1'b0;
			host_fail_reg <= 1'b0;
		end else begin
			orng_fault_o <= orng_next;
			out_shutdown_o <= shut_next;
			host_fail_reg <= host_fail_next;
		end
	end

	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			unit_flags_high_reg <= `RSA_UNIT_HIGH_RST;
			unit_flags_low_reg <= `RSA_UNIT_LOW_RST;
			alarm_byte_three_reg <= `RSA_ALARM_RST;
			alarm_byte_two_reg <= `RSA_ALARM_RST;
			alarm_byte_one_reg <= `RSA_ALARM_RST;
		end else begin
			unit_flags_high_reg <= {pec_err_i, oc_hiccup_i, bad_instr_i,
				1'b0, host_fail_next, 1'b0, value_range_flag_i,
				remote_on_i};
			unit_flags_low_reg <= {ot_hiccup_i, orng_ok_i,
				internal_fault_i, shutdown_i | shut_next, service_led_i,
				external_fault_i, led_test_i, output_on_i};
			alarm_byte_three_reg <= {alarm_three_src_i, 2'b00,
				orng_next};
			alarm_byte_two_reg <= {alarm_two_src_i,
				share_ma_i > `RSA_SHARE_LIMIT_MA};
			alarm_byte_one_reg <= alarm_one_src_i;
		end
	end

	// ==========================================
	// hottest sensor relative to its limit
	wire [NSENS*17-1:0] margin_w;
	genvar g;
	generate
		for (g = 0; g < NSENS; g = g + 1) begin : g_margin
			assign margin_w[g*17 +: 17] = {1'b0, temp_limit_i[g*16 +: 16]}
				- {1'b0, temp_i[g*16 +: 16]};
		end
	endgenerate

	integer s;
	reg [15:0] temp_pick;
	reg signed [16:0] best_margin;

	always @* begin
		temp_pick = temp_i[15:0];
		best_margin = margin_w[16:0];
		for (s = 1; s < NSENS; s = s + 1) begin
			if ($signed(margin_w[s*17 +: 17]) < best_margin) begin
				best_margin = margin_w[s*17 +: 17];
				temp_pick = temp_i[s*16 +: 16];
			end
		end
	end

	// ==========================================
	// frame assembly
	reg [7:0] cmd_reg;
	reg [95:0] frame_next;
	reg [3:0] len_next;

	always @* begin
		frame_next = 96'h0;
		len_next = 4'h0;
		case (cmd_reg)
			`RSA_CMD_SUMMARY: begin
				frame_next = {temp_pick, iout_i, vout_i,
					alarm_byte_one_reg, alarm_byte_two_reg,
					alarm_byte_three_reg, unit_flags_low_reg,
					unit_flags_high_reg, `RSA_SUMMARY_COUNT};
				len_next = `RSA_SUMMARY_LEN;
			end
			`RSA_CMD_UNIT: begin
				frame_next = {80'h0, unit_flags_low_reg,
					unit_flags_high_reg};
				len_next = `RSA_UNIT_LEN;
			end
			`RSA_CMD_ALARM: begin
				frame_next = {64'h0, alarm_byte_one_reg, alarm_byte_two_reg,
					alarm_byte_three_reg, `RSA_ALARM_COUNT};
				len_next = `RSA_ALARM_LEN;
			end
			default: begin
				frame_next = 96'h0;
				len_next = 4'h0;
			end
		endcase
	end

	// ==========================================
	// packet error check chain
	wire [7:0] pec_wr_addr;
	wire [7:0] pec_cmd;
	wire [7:0] pec_rd_addr;
	wire [7:0] pec_byte;
	reg [7:0] pec_reg;
	reg [95:0] frame_reg;
	reg [3:0] len_reg;
	reg [3:0] idx_reg;
	reg [7:0] byte_sel;

	rsa_pec8 u_pec_wa (
		.crc_i(`RSA_PEC_INIT),
		.data_i({SLAVE_ADDR, 1'b0}),
		.crc_o(pec_wr_addr)
	);

	rsa_pec8 u_pec_cmd (
		.crc_i(pec_wr_addr),
		.data_i(cmd_code_i),
		.crc_o(pec_cmd)
	);

	rsa_pec8 u_pec_ra (
		.crc_i(pec_reg),
		.data_i({SLAVE_ADDR, 1'b1}),
		.crc_o(pec_rd_addr)
	);

	rsa_pec8 u_pec_dat (
		.crc_i(pec_reg),
		.data_i(byte_sel),
		.crc_o(pec_byte)
	);

	always @* begin
		if (idx_reg < len_reg)
			byte_sel = frame_reg[{idx_reg, 3'b000} +: 8];
		else if (idx_reg == len_reg)
			byte_sel = pec_reg;
		else
			byte_sel = `RSA_FILL_BYTE;
	end

	// ==========================================
	// read sequencing
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cmd_reg <= 8'h00;
			pec_reg <= `RSA_PEC_INIT;
			frame_reg <= 96'h0;
			len_reg <= 4'h0;
			idx_reg <= 4'h0;
			rd_data_o <= 8'h00;
			rd_valid_o <= 1'b0;
		end else begin
			rd_valid_o <= 1'b0;
			if (cmd_valid_i) begin
				cmd_reg <= cmd_code_i;
				pec_reg <= pec_cmd;
				len_reg <= 4'h0;
				idx_reg <= 4'h0;
			end else if (rd_start_i) begin
				frame_reg <= frame_next;
				len_reg <= len_next;
				idx_reg <= 4'h0;
				pec_reg <= pec_rd_addr;
			end else if (rd_req_i) begin
				rd_data_o <= byte_sel;
				rd_valid_o <= 1'b1;
				if (idx_reg < len_reg)
					pec_reg <= pec_byte;
				if (idx_reg != 4'hf)
					idx_reg <= idx_reg + 4'h1;
			end
		end
	end

endmodule // rsa_bank

/* tb/rsa_host.sv */
// Purpose: host model of the byte port
// Assumes: one request per cycle
// Notes: answered bytes gather in got
`timescale 1ns/1ps
module rsa_host (
	input logic clk_i,
	input logic [7:0] rd_data_i,
	input logic rd_valid_i,
	output logic cmd_valid_o = 0,
	output logic [7:0] cmd_code_o = 0,
	output logic rd_start_o = 0,
	output logic rd_req_o = 0
);
	logic [7:0] got[$];
	always @(posedge clk_i) if (rd_valid_i) got.push_back(rd_data_i);
	task automatic read(input logic [7:0] cmd, input int n);
		got = {};
		@(posedge clk_i);
		cmd_valid_o <= 1;
		cmd_code_o <= cmd;
		@(posedge clk_i);
		cmd_valid_o <= 0;
		cmd_code_o <= ~cmd;
		rd_start_o <= 1;
		@(posedge clk_i);
		rd_start_o <= 0;
		rd_req_o <= 1;
		repeat (n) @(posedge clk_i);
		rd_req_o <= 0;
		repeat (2) @(posedge clk_i);
	endtask
endmodule // rsa_host

/* tb/rsa_bank_sva.sv */
// Purpose: port assertions of the bank
// Assumes: one clock, async low reset
// Notes: bound from the bench top
`timescale 1ns/1ps
module rsa_bank_sva (
	input logic clk_i,
	input logic rstn_i,
	input logic cmd_valid_i,
	input logic [7:0] cmd_code_i,
	input logic rd_start_i,
	input logic rd_req_i,
	input logic host_test_fail_i,
	input logic self_test_fail_i,
	input logic orng_destructive_i,
	input logic orng_clear_i,
	input logic [7:0] rd_data_o,
	input logic rd_valid_o,
	input logic out_shutdown_o,
	input logic orng_fault_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);
	wire rq = rd_req_i && !cmd_valid_i && !rd_start_i;
	wire f = host_test_fail_i || self_test_fail_i;
	wire fd = f && orng_destructive_i;
	a_byte_answer: assert property (rq |=> rd_valid_o)
		else $error("no byte after request");
	a_no_stray: assert property (!rq |=> !rd_valid_o)
		else $error("stray byte");
	a_fault_set: assert property (f |=> orng_fault_o)
		else $error("fault not set");
	a_fault_holds: assert property (orng_fault_o && !orng_clear_i
		|=> orng_fault_o)
		else $error("fault dropped");
	a_fault_clear: assert property (orng_clear_i && !f |=> !orng_fault_o)
		else $error("fault not cleared");
	a_trip_output: assert property (fd |=> out_shutdown_o)
		else $error("no shutdown");
	a_mild_fault: assert property (!out_shutdown_o && !fd
		|=> !out_shutdown_o)
		else $error("needless shutdown");
	a_sum_count: assert property (cmd_valid_i && cmd_code_i == 8'hd0 ##1
		rd_start_i && !cmd_valid_i ##1 rq |=> rd_data_o == 8'h0b)
		else $error("bad summary count");
	a_alarm_count: assert property (cmd_valid_i && cmd_code_i == 8'hd2 ##1
		rd_start_i && !cmd_valid_i ##1 rq |=> rd_data_o == 8'h03)
		else $error("bad alarm count");
	c_sum: cover property (cmd_valid_i && cmd_code_i == 8'hd0);
	c_trip: cover property ($rose(out_shutdown_o));
	c_fault: cover property ($rose(orng_fault_o));
endmodule // rsa_bank_sva

/* tb/test_rsa_bank.sv */
// Purpose: self-checking bench of the bank
// Assumes: host model drives the byte port
// Notes: bench model builds every frame
`timescale 1ns/1ps
module test_rsa_bank;
	logic clk_i = 0;
	logic rstn_i = 0;
	logic [4:0] uh_in = 0;
	logic [7:0] ul_in = 0;
	logic [4:0] a3s = 0;
	logic [6:0] a2s = 0;
	logic [7:0] a1s = 0;
	logic hf = 0;
	logic sf = 0;
	logic dst = 0;
	logic clr = 0;
	logic [15:0] share = 0;
	logic [15:0] vo = 0;
	logic [15:0] io = 0;
	logic [47:0] tmp = 0;
	logic [47:0] lim = 0;
	logic [47:0] t;
	logic [47:0] l;
	logic hflag = 0;
	logic orng = 0;
	logic shut = 0;
	logic [7:0] exp[$];
	int n_mismatch = 0;
	int samples_checked = 0;
	wire cv;
	wire rs;
	wire rq;
	wire rv;
	wire sd;
	wire of;
	wire [7:0] cc;
	wire [7:0] rd;
	always #2.5 clk_i = ~clk_i;
	rsa_host h (.clk_i, .rd_data_i(rd), .rd_valid_i(rv), .cmd_valid_o(cv),
		.cmd_code_o(cc), .rd_start_o(rs), .rd_req_o(rq));
	rsa_bank dut (.clk_i, .rstn_i, .cmd_valid_i(cv), .cmd_code_i(cc),
		.rd_start_i(rs), .rd_req_i(rq), .pec_err_i(uh_in[4]),
		.oc_hiccup_i(uh_in[3]), .bad_instr_i(uh_in[2]),
		.value_range_flag_i(uh_in[1]), .remote_on_i(uh_in[0]),
		.ot_hiccup_i(ul_in[7]), .orng_ok_i(ul_in[6]),
		.internal_fault_i(ul_in[5]), .shutdown_i(ul_in[4]),
		.service_led_i(ul_in[3]), .external_fault_i(ul_in[2]),
		.led_test_i(ul_in[1]), .output_on_i(ul_in[0]),
		.alarm_three_src_i(a3s), .alarm_two_src_i(a2s),
		.alarm_one_src_i(a1s), .host_test_fail_i(hf),
		.self_test_fail_i(sf), .orng_destructive_i(dst),
		.orng_clear_i(clr), .share_ma_i(share), .vout_i(vo), .iout_i(io),
		.temp_i(tmp), .temp_limit_i(lim), .rd_data_o(rd), .rd_valid_o(rv),
		.out_shutdown_o(sd), .orng_fault_o(of));
	function automatic logic [7:0] crc8(logic [7:0] c, logic [7:0] d);
		c = c ^ d;
		repeat (8) c = c[7] ? (c << 1) ^ 8'h07 : c << 1;
		return c;
	endfunction
	task automatic build(input logic [7:0] cmd);
		logic [7:0] uh;
		logic [7:0] ul;
		logic [7:0] a3;
		logic [7:0] a2;
		logic [7:0] p;
		logic [15:0] tv;
		int b;
		uh = {uh_in[4:2], 1'b0, hflag, 1'b0, uh_in[1:0]};
		ul = ul_in | {3'b0, shut, 4'b0};
		a3 = {a3s, 2'b0, orng};
		a2 = {a2s, share > 16'd10000};
		b = 0;
		for (int k = 1; k < 3; k++)
			if (lim[16*k+:16] - tmp[16*k+:16] < lim[16*b+:16] - tmp[16*b+:16])
				b = k;
		tv = tmp[16*b+:16];
		exp = {};
		if (cmd == 8'hd0)
			exp = {8'h0b, uh, ul, a3, a2, a1s, vo[7:0], vo[15:8], io[7:0],
				io[15:8], tv[7:0], tv[15:8]};
		if (cmd == 8'hd1)
			exp = {uh, ul};
		if (cmd == 8'hd2)
			exp = {8'h03, a3, a2, a1s};
		p = crc8(crc8(crc8(8'h00, {7'h58, 1'b0}), cmd), {7'h58, 1'b1});
		foreach (exp[i]) p = crc8(p, exp[i]);
		exp.push_back(p);
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rd_frame(input logic [7:0] cmd);
		build(cmd);
		h.read(cmd, exp.size());
		chk("frame_len", 8'(exp.size()), 8'(h.got.size()));
		foreach (exp[i]) chk("frame_byte", exp[i], h.got[i]);
	endtask
	task automatic fault(input logic hv, input logic dv, input logic cl);
		@(posedge clk_i);
		hf <= hv & !cl;
		sf <= !hv & !cl;
		dst <= dv;
		clr <= cl;
		@(posedge clk_i);
		{hf, sf, dst, clr} <= 4'h0;
		orng = !cl;
		hflag = cl ? 1'b0 : hflag | hv;
		shut = cl ? 1'b0 : shut | dv;
		@(posedge clk_i);
		chk("orng_fault", {7'h0, orng}, {7'h0, of});
		chk("shutdown", {7'h0, shut}, {7'h0, sd});
		rd_frame(8'hd1);
		rd_frame(8'hd2);
		$display("fault test %b%b%b done", hv, dv, cl);
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		void'($urandom(32'h5b23));
		repeat (6) @(posedge clk_i);
		rstn_i <= 1;
		for (int i = 0; i < 8; i++) begin
			for (int k = 0; k < 3; k++) begin
				t[16*k+:16] = 16'($urandom_range(16'h7fff));
				l[16*k+:16] = t[16*k+:16] + 16'($urandom_range(255));
			end
			@(posedge clk_i);
			{uh_in, ul_in, a3s, a2s, a1s} <= 33'($urandom) ^ {$urandom, 1'b0};
			{vo, io} <= $urandom;
			share <= 16'd9998 + 16'(i % 4);
			tmp <= t;
			lim <= l;
			repeat (2) @(posedge clk_i);
			rd_frame(8'hd0);
			rd_frame(8'hd1);
			rd_frame(8'hd2);
			rd_frame(8'he0);
			$display("flag test %0d done", i);
		end
		fault(1, 0, 0);
		fault(0, 0, 1);
		fault(0, 1, 0);
		fault(0, 0, 1);
		fault(0, 1, 0);
		@(posedge clk_i);
		rstn_i <= 0;
		repeat (2) @(posedge clk_i);
		chk("reset_out", 8'h00, {5'h0, rv, sd, of});
		rstn_i <= 1;
		{orng, shut, hflag} = 3'b000;
		rd_frame(8'hd2);
		$display("reset test done");
		report_and_stop();
	end
	initial begin
		#20000;
		n_mismatch++;
		report_and_stop();
	end
endmodule // test_rsa_bank
bind rsa_bank rsa_bank_sva u_sva (.clk_i, .rstn_i, .cmd_valid_i, .cmd_code_i,
	.rd_start_i, .rd_req_i, .host_test_fail_i, .self_test_fail_i,
	.orng_destructive_i, .orng_clear_i, .rd_data_o, .rd_valid_o,
	.out_shutdown_o, .orng_fault_o);
